/* rtl/bft_pkg.sv */
// package of the break field timer and receive assist block
// assumes one 200 MHz clock and a plain word-wide register port
package bft_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFF_EXT_CONTROL_0 = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_EXT_CONTROL_2 = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_EXT_IRQ_CONTROL = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_EXT_STATUS = 5'h0c;
	localparam logic [ADDR_W-1:0] OFF_TIMER_MODE_REG = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL_REG = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_PRESCALE = 5'h18;
	localparam logic [ADDR_W-1:0] OFF_MAIN_COUNT = 5'h1c;
	// ****************************************
	// field positions
	// ****************************************
	localparam int BIT_RATE_MEASURE_ENABLE = 0;
	localparam int BIT_BREAK_DETECT_ENABLE = 1;
	localparam int POS_FILTER_CLOCK_SELECT = 0;
	localparam int POS_SAMPLE_TIMING = 4;
	localparam int BIT_BASE_CLOCK_HALVING = 6;
	localparam int BIT_BREAK_IRQ_ENABLE = 0;
	localparam int BIT_EDGE_EVENT_IRQ_ENABLE = 1;
	localparam int BIT_BREAK_DETECTED = 0;
	localparam int BIT_BREAK_SEEN = 1;
	localparam int BIT_HOLD = 2;
	localparam int POS_TIMER_MODE = 0;
	localparam int POS_TIMER_CLOCK_SOURCE = 4;
	localparam int BIT_TIMER_START = 0;
	// ****************************************
	// modes, states, reset values
	// ****************************************
	localparam logic [1:0] MODE_PLAIN_TIMER = 2'h0;
	localparam logic [1:0] MODE_BREAK_DETERMINE = 2'h1;
	localparam logic [1:0] MODE_BREAK_OUTPUT = 2'h2;
	localparam logic [3:0] SAMPLE_BASE_FULL = 4'h8;
	localparam logic [3:0] SAMPLE_BASE_HALF = 4'h4;
	localparam logic [7:0] RST_PRESCALE = 8'hff;
	localparam logic [7:0] RST_MAIN_COUNT = 8'hff;
	typedef enum logic [1:0] {T_IDLE = 2'b00, T_READY = 2'b01, T_COUNT = 2'b11} bft_tstate_e;
	typedef struct packed {
		logic [2:0] filter_clock_select;
		logic [1:0] sample_timing;
		logic base_clock_halving_select;
		logic [1:0] timer_mode_select;
		logic [2:0] timer_clock_source_select;
	} bft_cfg_s;
	localparam bft_cfg_s RST_CFG = 11'h000;
endpackage

/* rtl/bft_rx_filter.sv */
// three stage filter on the receive pin: the level changes only when all three samples agree
// assumes the sample tick is a one-cycle pulse of the module clock
`timescale 1ns/1ps
`default_nettype none
module bft_rx_filter
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic sample_tick_i,
	input wire logic pin_i,
	output logic level_o
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_level;

	// ****************************************
	// sample shift and match
	// ****************************************
	always_comb
	begin
		next_stage = stage;
		next_level = level_o;
		if (sample_tick_i)
		begin
			next_stage = {stage[1:0], pin_i};
		end
		if (stage == 3'h7)
		begin
			next_level = 1'b1;
		end
		else if (stage == 3'h0)
		begin
			next_level = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			stage <= 3'h7;
			level_o <= 1'b1;
		end
		else
		begin
			stage <= next_stage;
			level_o <= next_level;
		end
	end

	property p_filter_hold;
		@(posedge CLOCK_I) disable iff (SYS_RST_I)
		(stage != 3'h7 && stage != 3'h0) |=> level_o == $past(level_o);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter changed without match");
endmodule
`default_nettype wire

/* rtl/bft_top.sv */
// break field timer, receive filter, rate measurement and sample timing
// assumes a plain register port: strobes one cycle, read data one cycle later
//Contract
//- receive filter needs three agreeing samples
//- filter sample clock chosen by three-bit field
//- measurement enabled by bit, paused during break
//- measurement begins when line high after break
//- each edge captures counters unless hold is set, reloads, edge interrupt
//- captured values held until software reads them
//- sample timing picks base cycle 8,10,12,14
//- halving select picks clock cycle 4 to 7
//- mode field: output, determine, plain timer
//- counter clock source chosen by three-bit field
//- output mode start drives transmit low, counts
//- output underflow drives high, sets break flag
//- start cleared reloads counters then stops
//- determine start waits ready, low starts count
//- determine high level reloads, returns to ready
//- determine underflow sets flag and interrupt
//- plain timer runs while start bit one
//- prescaler underflow steps the main down counter
//- plain timer underflow sets flag and interrupt
//- receive to channel blocked during break detection
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bft_top
#(
	parameter int CNT_W = 8
)
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic [bft_pkg::ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic RECEIVE_PIN_I,
	output logic TRANSMIT_PIN_O,
	output logic RXD_TO_CHANNEL_O,
	output logic [3:0] SAMPLE_CYCLE_O,
	output logic BREAK_INTERRUPT_O,
	output logic EDGE_EVENT_INTERRUPT_O
);
	import bft_pkg::*;

	function automatic logic tick_of(input logic [7:0] div, input logic [2:0] sel);
		logic [7:0] m;
		m = 8'((9'h1 << sel) - 9'h1);
		return (div & m) == m;
	endfunction

	logic rate_measure_enable, break_detect_enable, break_irq_enable, edge_event_irq_enable;
	logic break_detected_flag, break_seen, rx_pass, measuring, hold, rx_prev;
	bft_cfg_s cfg;
	bft_tstate_e tstate;
	logic [CNT_W-1:0] pre_set, main_set, prescale_down_counter, main_down_counter;
	logic [CNT_W-1:0] pre_buf, main_buf;
	logic [7:0] div;
	logic rx_level, filt_tick, src_tick;

	logic next_rate_measure_enable, next_break_detect_enable;
	logic next_break_irq_enable, next_edge_event_irq_enable;
	logic next_break_detected_flag, next_break_seen, next_rx_pass, next_measuring, next_hold;
	bft_cfg_s next_cfg;
	bft_tstate_e next_tstate;
	logic [CNT_W-1:0] next_pre_set, next_main_set, next_pre, next_main, next_pre_buf, next_main_buf;
	logic [7:0] next_div;
	logic [31:0] next_rdata;
	logic next_txd, next_rxd_ch, next_brk_irq, next_edge_irq;
	logic [3:0] next_sample_cycle;
	logic counting, underflow, brk_event, edge_seen, break_field, tcr_wr, reload;

	// ****************************************
	// receive filter
	// ****************************************
	assign filt_tick = tick_of(div, cfg.filter_clock_select);
	assign src_tick = tick_of(div, cfg.timer_clock_source_select);

	bft_rx_filter bft_rx_filter_i
	(
		.CLOCK_I(CLOCK_I),
		.SYS_RST_I(SYS_RST_I),
		.sample_tick_i(filt_tick),
		.pin_i(RECEIVE_PIN_I),
		.level_o(rx_level)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_rate_measure_enable = rate_measure_enable;
		next_break_detect_enable = break_detect_enable;
		next_break_irq_enable = break_irq_enable;
		next_edge_event_irq_enable = edge_event_irq_enable;
		next_break_detected_flag = break_detected_flag;
		next_break_seen = break_seen;
		next_rx_pass = rx_pass;
		next_measuring = measuring;
		next_hold = hold;
		next_cfg = cfg;
		next_tstate = tstate;
		next_pre_set = pre_set;
		next_main_set = main_set;
		next_pre = prescale_down_counter;
		next_main = main_down_counter;
		next_pre_buf = pre_buf;
		next_main_buf = main_buf;
		next_div = div + 8'h1;
		next_rdata = 32'h0;
		next_txd = TRANSMIT_PIN_O;
		next_brk_irq = 1'b0;
		next_edge_irq = 1'b0;
		tcr_wr = WR_I && ADDR_I == OFF_TIMER_CONTROL_REG;
		reload = 1'b0;
		// a low level seen once measuring has begun is data, not a break field
		break_field = cfg.timer_mode_select == MODE_BREAK_DETERMINE && tstate == T_COUNT
			&& !measuring;
		edge_seen = rx_level != rx_prev;
		counting = tstate == T_COUNT || (measuring && !break_field);
		underflow = 1'b0;
		// counter chain
		if (counting && src_tick)
		begin
			if (prescale_down_counter == '0)
			begin
				next_pre = pre_set;
				if (main_down_counter == '0)
				begin
					underflow = 1'b1;
					next_main = main_set;
				end
				else
				begin
					next_main = main_down_counter - 1'b1;
				end
			end
			else
			begin
				next_pre = prescale_down_counter - 1'b1;
			end
		end
		brk_event = underflow && tstate == T_COUNT;
		if (brk_event && cfg.timer_mode_select == MODE_BREAK_OUTPUT)
		begin
			next_txd = 1'b1;
		end
		if (brk_event && cfg.timer_mode_select == MODE_BREAK_DETERMINE)
		begin
			next_break_seen = 1'b1;
		end
		// break determination line tracking
		if (cfg.timer_mode_select == MODE_BREAK_DETERMINE)
		begin
			if (tstate == T_READY && !rx_level)
			begin
				next_tstate = T_COUNT;
			end
			else if (tstate == T_COUNT && rx_level)
			begin
				next_tstate = T_READY;
				reload = 1'b1;
			end
		end
		// rate measurement
		if (!rate_measure_enable)
		begin
			next_measuring = 1'b0;
		end
		else if (!measuring && break_seen && rx_level && !break_field)
		begin
			next_measuring = 1'b1;
			reload = 1'b1;
		end
		else if (measuring && edge_seen && !break_field)
		begin
			if (!hold)
			begin
				next_pre_buf = prescale_down_counter;
				next_main_buf = main_down_counter;
				next_hold = 1'b1;
			end
			reload = 1'b1;
			next_edge_irq = edge_event_irq_enable;
		end
		// receive path blocking
		if (!break_detect_enable)
		begin
			next_rx_pass = 1'b1;
		end
		else if (break_seen && rx_level)
		begin
			next_rx_pass = 1'b1;
		end
		// register writes
		if (WR_I)
		begin
			case (ADDR_I)
				OFF_EXT_CONTROL_0:
				begin
					next_rate_measure_enable = WDATA_I[BIT_RATE_MEASURE_ENABLE];
					next_break_detect_enable = WDATA_I[BIT_BREAK_DETECT_ENABLE];
					if (WDATA_I[BIT_BREAK_DETECT_ENABLE] && !break_detect_enable)
					begin
						next_rx_pass = 1'b0;
						next_break_seen = 1'b0;
					end
				end
				OFF_EXT_CONTROL_2:
				begin
					next_cfg.filter_clock_select = WDATA_I[POS_FILTER_CLOCK_SELECT +: 3];
					next_cfg.sample_timing = WDATA_I[POS_SAMPLE_TIMING +: 2];
					next_cfg.base_clock_halving_select = WDATA_I[BIT_BASE_CLOCK_HALVING];
				end
				OFF_EXT_IRQ_CONTROL:
				begin
					next_break_irq_enable = WDATA_I[BIT_BREAK_IRQ_ENABLE];
					next_edge_event_irq_enable = WDATA_I[BIT_EDGE_EVENT_IRQ_ENABLE];
				end
				OFF_EXT_STATUS:
				begin
					if (WDATA_I[BIT_BREAK_DETECTED])
					begin
						next_break_detected_flag = 1'b0;
					end
				end
				OFF_TIMER_MODE_REG:
				begin
					next_cfg.timer_mode_select = WDATA_I[POS_TIMER_MODE +: 2];
					next_cfg.timer_clock_source_select = WDATA_I[POS_TIMER_CLOCK_SOURCE +: 3];
				end
				OFF_TIMER_CONTROL_REG:
				begin
					if (WDATA_I[BIT_TIMER_START])
					begin
						case (cfg.timer_mode_select)
							MODE_BREAK_OUTPUT:
							begin
								next_tstate = T_COUNT;
								next_txd = 1'b0;
							end
							MODE_BREAK_DETERMINE:
							begin
								next_tstate = T_READY;
								next_break_seen = 1'b0;
								reload = 1'b1;
							end
							MODE_PLAIN_TIMER:
							begin
								next_tstate = T_COUNT;
							end
							default:
							begin
								next_tstate = tstate;
							end
						endcase
					end
					else
					begin
						next_tstate = T_IDLE;
						next_txd = 1'b1;
						reload = 1'b1;
					end
				end
				OFF_PRESCALE:
				begin
					next_pre_set = WDATA_I[CNT_W-1:0];
					reload = 1'b1;
				end
				OFF_MAIN_COUNT:
				begin
					next_main_set = WDATA_I[CNT_W-1:0];
					reload = 1'b1;
				end
				default:
				begin
					next_cfg = next_cfg;
				end
			endcase
		end
		if (reload)
		begin
			next_pre = WR_I && ADDR_I == OFF_PRESCALE ? WDATA_I[CNT_W-1:0] : pre_set;
			next_main = WR_I && ADDR_I == OFF_MAIN_COUNT ? WDATA_I[CNT_W-1:0] : main_set;
		end
		// set wins over clear
		if (brk_event)
		begin
			next_break_detected_flag = 1'b1;
			next_brk_irq = break_irq_enable;
		end
		// register reads
		if (RD_I)
		begin
			case (ADDR_I)
				OFF_EXT_CONTROL_0:
					next_rdata = 32'({break_detect_enable, rate_measure_enable});
				OFF_EXT_CONTROL_2:
					next_rdata = 32'({cfg.base_clock_halving_select, cfg.sample_timing, 1'b0,
						cfg.filter_clock_select});
				OFF_EXT_IRQ_CONTROL:
					next_rdata = 32'({edge_event_irq_enable, break_irq_enable});
				OFF_EXT_STATUS:
					next_rdata = 32'({hold, break_seen, break_detected_flag});
				OFF_TIMER_MODE_REG:
					next_rdata = 32'({cfg.timer_clock_source_select, 2'h0, cfg.timer_mode_select});
				OFF_TIMER_CONTROL_REG:
					next_rdata = 32'(tstate != T_IDLE);
				OFF_PRESCALE:
				begin
					next_rdata = 32'(hold ? pre_buf : prescale_down_counter);
					next_hold = next_hold && !hold;
				end
				OFF_MAIN_COUNT:
				begin
					next_rdata = 32'(hold ? main_buf : main_down_counter);
					next_hold = next_hold && !hold;
				end
				default:
					next_rdata = 32'h0;
			endcase
		end
		next_rxd_ch = rx_pass ? rx_level : 1'b1;
		if (cfg.base_clock_halving_select)
		begin
			next_sample_cycle = SAMPLE_BASE_HALF + {2'h0, cfg.sample_timing};
		end
		else
		begin
			next_sample_cycle = SAMPLE_BASE_FULL + {1'h0, cfg.sample_timing, 1'b0};
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			rate_measure_enable <= 1'b0;
			break_detect_enable <= 1'b0;
			break_irq_enable <= 1'b0;
			edge_event_irq_enable <= 1'b0;
			break_detected_flag <= 1'b0;
			break_seen <= 1'b0;
			rx_pass <= 1'b1;
			measuring <= 1'b0;
			hold <= 1'b0;
			rx_prev <= 1'b1;
			cfg <= RST_CFG;
			tstate <= T_IDLE;
			pre_set <= CNT_W'(RST_PRESCALE);
			main_set <= CNT_W'(RST_MAIN_COUNT);
			prescale_down_counter <= CNT_W'(RST_PRESCALE);
			main_down_counter <= CNT_W'(RST_MAIN_COUNT);
			pre_buf <= '0;
			main_buf <= '0;
			div <= 8'h0;
			RDATA_O <= 32'h0;
			TRANSMIT_PIN_O <= 1'b1;
			RXD_TO_CHANNEL_O <= 1'b1;
			SAMPLE_CYCLE_O <= SAMPLE_BASE_FULL;
			BREAK_INTERRUPT_O <= 1'b0;
			EDGE_EVENT_INTERRUPT_O <= 1'b0;
		end
		else
		begin
			rate_measure_enable <= next_rate_measure_enable;
			break_detect_enable <= next_break_detect_enable;
			break_irq_enable <= next_break_irq_enable;
			edge_event_irq_enable <= next_edge_event_irq_enable;
			break_detected_flag <= next_break_detected_flag;
			break_seen <= next_break_seen;
			rx_pass <= next_rx_pass;
			measuring <= next_measuring;
			hold <= next_hold;
			rx_prev <= rx_level;
			cfg <= next_cfg;
			tstate <= next_tstate;
			pre_set <= next_pre_set;
			main_set <= next_main_set;
			prescale_down_counter <= next_pre;
			main_down_counter <= next_main;
			pre_buf <= next_pre_buf;
			main_buf <= next_main_buf;
			div <= next_div;
			RDATA_O <= next_rdata;
			TRANSMIT_PIN_O <= next_txd;
			RXD_TO_CHANNEL_O <= next_rxd_ch;
			SAMPLE_CYCLE_O <= next_sample_cycle;
			BREAK_INTERRUPT_O <= next_brk_irq;
			EDGE_EVENT_INTERRUPT_O <= next_edge_irq;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_out_start;
		tcr_wr && WDATA_I[0] && cfg.timer_mode_select == MODE_BREAK_OUTPUT
			|=> !TRANSMIT_PIN_O && tstate == T_COUNT;
	endproperty
	a_out_start: assert property (p_out_start) else $error("break output did not start");
	property p_out_underflow;
		brk_event && cfg.timer_mode_select == MODE_BREAK_OUTPUT && !tcr_wr
			|=> TRANSMIT_PIN_O && break_detected_flag;
	endproperty
	a_out_underflow: assert property (p_out_underflow) else $error("break end missing");
	property p_stop_reload;
		tcr_wr && !WDATA_I[0] |=> tstate == T_IDLE && prescale_down_counter == pre_set
			&& main_down_counter == main_set;
	endproperty
	a_stop_reload: assert property (p_stop_reload) else $error("stop without reload");
	property p_det_ready;
		tcr_wr && WDATA_I[0] && cfg.timer_mode_select == MODE_BREAK_DETERMINE |=> tstate == T_READY;
	endproperty
	a_det_ready: assert property (p_det_ready) else $error("ready state not entered");
	property p_det_high;
		break_field && rx_level && !WR_I |=> tstate == T_READY && main_down_counter == main_set;
	endproperty
	a_det_high: assert property (p_det_high) else $error("high level did not rearm");
	property p_irq_pulse;
		brk_event && break_irq_enable
			|=> BREAK_INTERRUPT_O ##1 (!BREAK_INTERRUPT_O || $past(brk_event));
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("break interrupt pulse wrong");
	property p_flag_sticky;
		break_detected_flag && !(WR_I && ADDR_I == OFF_EXT_STATUS) |=> break_detected_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("break flag lost");
	property p_edge_capture;
		measuring && edge_seen && !break_field && !hold && rate_measure_enable
			|=> hold && main_buf == $past(main_down_counter)
			&& EDGE_EVENT_INTERRUPT_O == $past(edge_event_irq_enable);
	endproperty
	a_edge_capture: assert property (p_edge_capture) else $error("edge capture wrong");
	property p_prescale_step;
		tstate == T_COUNT && src_tick && prescale_down_counter != '0 && !WR_I && !reload
			|=> prescale_down_counter == $past(prescale_down_counter) - 1'b1;
	endproperty
	a_prescale_step: assert property (p_prescale_step) else $error("prescaler did not step");
	property p_sample_point;
		!(WR_I && ADDR_I == OFF_EXT_CONTROL_2) ##1 1'b1
			|=> SAMPLE_CYCLE_O == ($past(cfg.base_clock_halving_select)
			? 4'h4 + {2'h0, $past(cfg.sample_timing)} : 4'h8 + {1'h0, $past(cfg.sample_timing), 1'b0});
	endproperty
	a_sample_point: assert property (p_sample_point) else $error("sample point wrong");

	c_break_out: cover property (brk_event && cfg.timer_mode_select == MODE_BREAK_OUTPUT);
	c_break_det: cover property (brk_event && cfg.timer_mode_select == MODE_BREAK_DETERMINE);
	c_edge_cap: cover property (EDGE_EVENT_INTERRUPT_O);
	c_hold_read: cover property (hold && RD_I && ADDR_I == OFF_MAIN_COUNT);
endmodule
`default_nettype wire

/* tb/bft_line_node.sv */
// model of another node on the shared serial line
// assumes the line idles high through a pull-up and is driven after an edge
`timescale 1ns/1ps
`default_nettype none
module bft_line_node
(
	input wire logic CLOCK_I,
	output logic line_o
);
	// ****************************************
	// line driver
	// ****************************************
	initial line_o = 1'b1;
	// hold a level for a number of clocks, changed just after an edge
	task automatic drive(input logic level, input int cycles);
		begin
			@(posedge CLOCK_I);
			line_o <= level;
			repeat (cycles - 1) @(posedge CLOCK_I);
		end
	endtask
endmodule
`default_nettype wire

/* tb/test_break_field_timer_rx_assist.sv */
// self-checking bench of the break field timer block
// assumes one 200 MHz clock and a partner node on the receive line
`timescale 1ns/1ps
`default_nettype none
module test_break_field_timer_rx_assist;
	import bft_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic line;
	logic txd;
	logic rxd;
	logic brk_irq;
	logic edge_irq;
	logic [3:0] smp;
	int failures = 0;
	int compares = 0;
	int brk_n = 0;
	int edge_n = 0;
	int low_n = 0;
	int n;
	int m;
	logic [31:0] v;
	// ****************************************
	// clock, design and partner
	// ****************************************
	always #2.5 clk = ~clk;
	bft_top bft_top_i (.CLOCK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RECEIVE_PIN_I(line), .TRANSMIT_PIN_O(txd),
		.RXD_TO_CHANNEL_O(rxd), .SAMPLE_CYCLE_O(smp), .BREAK_INTERRUPT_O(brk_irq),
		.EDGE_EVENT_INTERRUPT_O(edge_irq));
	bft_line_node bft_line_node_i (.CLOCK_I(clk), .line_o(line));
	always @(posedge clk)
	begin
		if (brk_irq === 1'b1) brk_n++;
		if (edge_irq === 1'b1) edge_n++;
		if (rxd === 1'b0) low_n++;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			compares++;
			if (seen !== exp)
			begin
				failures++;
				$display("Error at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			#1;
		end
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			d = rdata;
		end
	endtask
	task automatic tick(input int k);
		begin
			repeat (k) @(posedge clk);
			#1;
		end
	endtask
	task automatic drv(input logic level, input int k);
		begin
			bft_line_node_i.drive(level, k);
			#1;
		end
	endtask
	task automatic report_and_stop;
		begin
			$display("Comparisons %0d, mismatches %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_reset;
		begin
			tick(1);
			check({28'h0, txd, rxd, brk_irq, edge_irq}, 32'hc);
			check(32'(smp), 32'h8);
			rd_reg(OFF_EXT_STATUS, v);
			check(v, 32'h0);
			rd_reg(OFF_PRESCALE, v);
			check(v, 32'hff);
			rd_reg(5'h02, v);
			check(v, 32'h0);
			$display("test reset done");
		end
	endtask
	task automatic test_sample;
		begin
			for (int h = 0; h < 2; h++)
				for (int r = 0; r < 4; r++)
				begin
					wr_reg(OFF_EXT_CONTROL_2, 32'(h * 64 + r * 16));
					tick(1);
					check(32'(smp), h ? 32'(4 + r) : 32'(8 + 2 * r));
				end
			wr_reg(OFF_EXT_CONTROL_2, 32'h0);
			$display("test sample timing done");
		end
	endtask
	task automatic test_filter;
		begin
			n = low_n;
			drv(1'b0, 2);
			drv(1'b1, 10);
			check(32'(low_n - n), 32'h0);
			drv(1'b0, 10);
			check(32'(rxd), 32'h0);
			drv(1'b1, 10);
			wr_reg(OFF_EXT_CONTROL_2, 32'h3);
			drv(1'b1, 30);
			n = low_n;
			drv(1'b0, 10);
			drv(1'b1, 40);
			check(32'(low_n - n), 32'h0);
			drv(1'b0, 40);
			check(32'(rxd), 32'h0);
			drv(1'b1, 40);
			wr_reg(OFF_EXT_CONTROL_2, 32'h0);
			$display("test filter done");
		end
	endtask
	task automatic test_break_out;
		int k;
		begin
			wr_reg(OFF_EXT_IRQ_CONTROL, 32'h1);
			wr_reg(OFF_TIMER_MODE_REG, 32'(MODE_BREAK_OUTPUT));
			wr_reg(OFF_PRESCALE, 32'h1);
			wr_reg(OFF_MAIN_COUNT, 32'h2);
			n = brk_n;
			k = 0;
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h1);
			tick(1);
			check(32'(txd), 32'h0);
			while (brk_n == n && k < 50)
			begin
				tick(1);
				k++;
			end
			check(32'(txd), 32'h1);
			check(32'(brk_n - n), 32'h1);
			check(32'(k >= 3 && k <= 12), 32'h1);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h0);
			rd_reg(OFF_EXT_STATUS, v);
			check(v & 32'h1, 32'h1);
			rd_reg(OFF_MAIN_COUNT, v);
			check(v, 32'h2);
			wr_reg(OFF_EXT_STATUS, 32'h1);
			rd_reg(OFF_EXT_STATUS, v);
			check(v & 32'h1, 32'h0);
			$display("test break output done");
		end
	endtask
	task automatic test_plain;
		begin
			wr_reg(OFF_EXT_IRQ_CONTROL, 32'h0);
			wr_reg(OFF_TIMER_MODE_REG, 32'(MODE_PLAIN_TIMER));
			wr_reg(OFF_PRESCALE, 32'h0);
			wr_reg(OFF_MAIN_COUNT, 32'h3);
			n = brk_n;
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h1);
			tick(12);
			rd_reg(OFF_EXT_STATUS, v);
			check(v & 32'h1, 32'h1);
			check(32'(brk_n - n), 32'h0);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h0);
			tick(5);
			rd_reg(OFF_MAIN_COUNT, v);
			check(v, 32'h3);
			wr_reg(OFF_EXT_STATUS, 32'h1);
			wr_reg(OFF_TIMER_MODE_REG, 32'h20);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h1);
			tick(8);
			rd_reg(OFF_EXT_STATUS, v);
			check(v & 32'h1, 32'h0);
			tick(12);
			rd_reg(OFF_EXT_STATUS, v);
			check(v & 32'h1, 32'h1);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h0);
			wr_reg(OFF_EXT_STATUS, 32'h1);
			$display("test plain timer done");
		end
	endtask
	task automatic test_determine;
		begin
			wr_reg(OFF_PRESCALE, 32'h3);
			wr_reg(OFF_MAIN_COUNT, 32'h7);
			wr_reg(OFF_EXT_IRQ_CONTROL, 32'h3);
			wr_reg(OFF_TIMER_MODE_REG, 32'(MODE_BREAK_DETERMINE));
			wr_reg(OFF_EXT_CONTROL_0, 32'h3);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h1);
			n = brk_n;
			m = edge_n;
			drv(1'b0, 12);
			drv(1'b1, 12);
			check(32'(brk_n - n), 32'h0);
			drv(1'b0, 25);
			drv(1'b1, 1);
			drv(1'b0, 30);
			check(32'(rxd), 32'h1);
			check(32'(brk_n - n), 32'h1);
			check(32'(edge_n - m), 32'h0);
			drv(1'b1, 20);
			check(32'(edge_n - m), 32'h0);
			drv(1'b0, 20);
			check(32'(rxd), 32'h0);
			check(32'(edge_n - m), 32'h1);
			rd_reg(OFF_EXT_STATUS, v);
			check((v >> 2) & 32'h1, 32'h1);
			drv(1'b1, 20);
			check(32'(edge_n - m), 32'h2);
			rd_reg(OFF_MAIN_COUNT, v);
			check(32'(v < 32'h7), 32'h1);
			rd_reg(OFF_EXT_STATUS, v);
			check((v >> 2) & 32'h1, 32'h0);
			wr_reg(OFF_EXT_CONTROL_0, 32'h2);
			drv(1'b0, 20);
			drv(1'b1, 20);
			check(32'(edge_n - m), 32'h2);
			wr_reg(OFF_TIMER_CONTROL_REG, 32'h0);
			$display("test determination and measurement done");
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		test_reset;
		test_sample;
		test_filter;
		test_break_out;
		test_plain;
		test_determine;
		report_and_stop;
	end
endmodule
`default_nettype wire
